//--- verilog/arltim_pkg.sv
// Purpose: constants and types for the auto-reload 8-bit timer
// Assumes: apb with 32-bit data, one register per aligned word
// Notes:   printed offsets are not multiples of four, so they are indices
package arltim_pkg;

  // ----------------------------------------------------------------
  // register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] mode_control_idx = 8'he5;
  localparam logic [7:0] flag_idx         = 8'he6;
  localparam logic [7:0] clock_select_idx = 8'he7;
  localparam logic [7:0] reload_value_idx = 8'he9;
  localparam logic [7:0] match_value_idx  = 8'hea;
  localparam logic [7:0] live_counter_idx = 8'heb;
  localparam logic [9:0] mode_control_adr = {mode_control_idx, 2'b00};
  localparam logic [9:0] flag_adr         = {flag_idx, 2'b00};
  localparam logic [9:0] clock_select_adr = {clock_select_idx, 2'b00};
  localparam logic [9:0] reload_value_adr = {reload_value_idx, 2'b00};
  localparam logic [9:0] match_value_adr  = {match_value_idx, 2'b00};
  localparam logic [9:0] live_counter_adr = {live_counter_idx, 2'b00};

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int reload_now_bit   = 7;
  localparam int run_enable_bit   = 6;
  localparam int compare_ie_bit   = 3;
  localparam int wrap_ie_bit      = 2;
  localparam int match_flag_bit   = 1;
  localparam int wrap_flag_bit    = 0;
  localparam int divide_sel_lsb   = 5;
  localparam int source_sel_lsb   = 0;

  // ----------------------------------------------------------------
  // reset values and codes
  // ----------------------------------------------------------------
  localparam logic [7:0] mode_control_rst = 8'h00;
  localparam logic [7:0] mode_control_wmask = 8'h4c;
  localparam logic [7:0] clock_select_wmask = 8'he3;
  localparam logic [1:0] src_core          = 2'h0;
  localparam logic [1:0] src_core_div3     = 2'h1;
  localparam logic [1:0] div3_last         = 2'h2;
  localparam logic [7:0] count_max         = 8'hff;

  // ----------------------------------------------------------------
  // state record
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       run_enable;
    logic       compare_irq_enable;
    logic       wrap_irq_enable;
    logic [2:0] divide_select;
    logic [1:0] source_select;
    logic [7:0] reload_value;
    logic [7:0] match_value;
    logic [7:0] count_value;
    logic [6:0] divider_stage;
    logic [1:0] div3_count;
    logic       wrap_flag;
    logic       match_flag;
    logic       pready;
    logic [31:0] prdata;
    logic       pslverr;
    logic       irq_wrap;
    logic       irq_match;
  } arltim_state_type;

endpackage

//--- verilog/arltim_top.sv
// Purpose: 8-bit auto-reload up-counter with prescaler, apb registers
// Assumes: single clock pclk, asynchronous active-low reset presetn
// Notes:   one-cycle access; unmapped addresses answer pslverr
//
// What this block does
// - 8-bit up-counter steps on prescaler tick
// - prescaler fed by core clock or divided by 3
// - 7-bit prescaler, 8 taps, divide by 2^n
// - run enable clear freezes prescaler and counter
// - counter cleared on reset
// - live port write loads counter, read returns count
// - any counter load clears prescaler
// - overflow reloads counter from reload value
// - overflow sets wrap flag; request when enabled
// - count equal match while run enable is set sets match flag; request
// - reload-now copies reload value, reads zero
// - mode control resets to zero, read/write
// - flags read normally, writing one no effect
// - interrupt requests usable for wake from wait
// - source code 00 core, 01 divided by 3
// - divide codes 000..111 give 1 to 128
// - writing zero clears wrap or match flag
// - overflow is a count step taken at ff, which loads the reload value
`timescale 1ns/1ps
`default_nettype none

module arltim_top
#(
  parameter int count_bits   = 8,
  parameter int divider_bits = 7,
  parameter int tap_count    = 8
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             irq_wrap,
  output logic             irq_match
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  arltim_pkg::arltim_state_type state_reg;
  arltim_pkg::arltim_state_type state_next;

  // ----------------------------------------------------------------
  // helper signals
  // ----------------------------------------------------------------
  logic       src_tick;
  logic       pre_tick;
  logic [tap_count-1:0] tap_ready;
  logic [9:0] word_idx;
  logic [7:0] count_step;
  logic       wrap_event;
  logic       acc;
  logic       wr;
  logic       rd;
  logic       hit;
  logic [7:0] wbyte;
  logic [7:0] rbyte;
  logic       sw_load;
  logic [7:0] sw_value;
  logic [7:0] mc_read;

  // ----------------------------------------------------------------
  // elaboration checks: the state record fixes these widths
  // ----------------------------------------------------------------
  if (count_bits != $bits(state_reg.count_value))
  begin : g_count_check
    $error("count_bits does not match the state record");
  end
  if (divider_bits != $bits(state_reg.divider_stage))
  begin : g_divider_check
    $error("divider_bits does not match the state record");
  end
  if (tap_count != divider_bits + 1)
  begin : g_tap_check
    $error("tap_count must be one more than divider_bits");
  end
  if (tap_count != (1 << $bits(state_reg.divide_select)))
  begin : g_select_check
    $error("tap_count must match the divide select width");
  end

  // ----------------------------------------------------------------
  // address decode: word index of the byte address
  // ----------------------------------------------------------------
  assign word_idx = paddr[11:2];

  // ----------------------------------------------------------------
  // prescaler taps: tap n is ready when the low n stage bits are ones
  // ----------------------------------------------------------------
  for (genvar t = 0; t < tap_count; t++)
  begin : g_tap
    if (t == 0)
    begin : g_first
      assign tap_ready[t] = 1'b1;
    end
    else
    begin : g_rest
      assign tap_ready[t] = &state_reg.divider_stage[t-1:0];
    end
  end

  // ----------------------------------------------------------------
  // read-back mux
  // ----------------------------------------------------------------
  always_comb
  begin
    hit     = 1'b1;
    rbyte   = 8'h00;
    mc_read = 8'h00;
    mc_read[arltim_pkg::run_enable_bit] = state_reg.run_enable;
    mc_read[arltim_pkg::compare_ie_bit] = state_reg.compare_irq_enable;
    mc_read[arltim_pkg::wrap_ie_bit]    = state_reg.wrap_irq_enable;
    case (word_idx)
      {2'h0, arltim_pkg::mode_control_idx}:
        rbyte = mc_read & arltim_pkg::mode_control_wmask;
      {2'h0, arltim_pkg::flag_idx}:
      begin
        rbyte[arltim_pkg::match_flag_bit] = state_reg.match_flag;
        rbyte[arltim_pkg::wrap_flag_bit]  = state_reg.wrap_flag;
      end
      {2'h0, arltim_pkg::clock_select_idx}:
        rbyte = {state_reg.divide_select, 3'h0, state_reg.source_select};
      {2'h0, arltim_pkg::reload_value_idx}:
        rbyte = state_reg.reload_value;
      {2'h0, arltim_pkg::match_value_idx}:
        rbyte = state_reg.match_value;
      {2'h0, arltim_pkg::live_counter_idx}:
        rbyte = state_reg.count_value;
      default:
        hit = 1'b0;
    endcase
  end

  always_comb
  begin
    state_next = state_reg;
    acc   = psel && penable;
    wr    = acc && pwrite;
    rd    = acc && !pwrite;
    wbyte = pwdata[7:0];
    sw_load  = 1'b0;
    sw_value = state_reg.reload_value;

    // --------------------------------------------------------------
    // clock source and prescaler
    // --------------------------------------------------------------
    if (state_reg.source_select == arltim_pkg::src_core_div3)
      src_tick = (state_reg.div3_count == arltim_pkg::div3_last);
    else
      src_tick = (state_reg.source_select == arltim_pkg::src_core);
    // tap n fires once every 2^n source ticks; tap 0 is the source itself
    pre_tick = src_tick && tap_ready[state_reg.divide_select];
    count_step = state_reg.count_value + 8'h01;
    wrap_event = state_reg.run_enable && pre_tick
      && (state_reg.count_value == arltim_pkg::count_max);

    if (state_reg.run_enable)
    begin
      if (state_reg.div3_count == arltim_pkg::div3_last)
        state_next.div3_count = 2'h0;
      else
        state_next.div3_count = state_reg.div3_count + 2'h1;
      if (src_tick)
        state_next.divider_stage = state_reg.divider_stage + 7'h01;
      if (pre_tick)
      begin
        if (wrap_event)
          state_next.count_value = state_reg.reload_value;
        else
          state_next.count_value = count_step;
        if (wrap_event)
          state_next.divider_stage = 7'h00;
      end
    end

    // --------------------------------------------------------------
    // register access
    // --------------------------------------------------------------
    case (word_idx)
      {2'h0, arltim_pkg::mode_control_idx}:
      begin
        if (wr)
        begin
          state_next.run_enable = wbyte[arltim_pkg::run_enable_bit];
          state_next.compare_irq_enable = wbyte[arltim_pkg::compare_ie_bit];
          state_next.wrap_irq_enable = wbyte[arltim_pkg::wrap_ie_bit];
          if (wbyte[arltim_pkg::reload_now_bit])
            sw_load = 1'b1;
        end
      end
      {2'h0, arltim_pkg::flag_idx}:
      begin
        if (wr && !wbyte[arltim_pkg::match_flag_bit])
          state_next.match_flag = 1'b0;
        if (wr && !wbyte[arltim_pkg::wrap_flag_bit])
          state_next.wrap_flag = 1'b0;
      end
      {2'h0, arltim_pkg::clock_select_idx}:
      begin
        if (wr)
        begin
          state_next.divide_select = wbyte[arltim_pkg::divide_sel_lsb +: 3];
          state_next.source_select = wbyte[arltim_pkg::source_sel_lsb +: 2];
        end
      end
      {2'h0, arltim_pkg::reload_value_idx}:
      begin
        if (wr)
          state_next.reload_value = wbyte;
      end
      {2'h0, arltim_pkg::match_value_idx}:
      begin
        if (wr)
          state_next.match_value = wbyte;
      end
      {2'h0, arltim_pkg::live_counter_idx}:
      begin
        if (wr)
        begin
          sw_load  = 1'b1;
          sw_value = wbyte;
        end
      end
      default:
        sw_value = state_reg.reload_value;
    endcase

    // --------------------------------------------------------------
    // counter loads from software
    // --------------------------------------------------------------
    // software load overrides the overflow reload
    if (sw_load)
    begin
      state_next.count_value   = sw_value;
      state_next.divider_stage = 7'h00;
      state_next.div3_count    = 2'h0;
    end

    // --------------------------------------------------------------
    // flags: a new event beats a clear in the same cycle
    // --------------------------------------------------------------
    if (wrap_event)
      state_next.wrap_flag = 1'b1;
    if (state_reg.count_value == state_reg.match_value
        && state_reg.run_enable)
      state_next.match_flag = 1'b1;
    state_next.irq_wrap  = state_next.wrap_flag
      && state_next.wrap_irq_enable;
    state_next.irq_match = state_next.match_flag
      && state_next.compare_irq_enable;

    // --------------------------------------------------------------
    // apb answer, one cycle in the access phase
    // --------------------------------------------------------------
    state_next.pready  = psel && !penable;
    state_next.pslverr = psel && !penable && !hit;
    state_next.prdata  = 32'h0000_0000;
    if (psel && !penable && !pwrite && hit)
      state_next.prdata = {24'h00_0000, rbyte};
    if (rd)
      state_next.prdata = 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------------------------------
  // outputs straight from the state register
  // ----------------------------------------------------------------
  assign pready    = state_reg.pready;
  assign prdata    = state_reg.prdata;
  assign pslverr   = state_reg.pslverr;
  assign irq_wrap  = state_reg.irq_wrap;
  assign irq_match = state_reg.irq_match;

endmodule

`default_nettype wire

//--- verification/arltim_asserts.sv
// Purpose: port checks for the timer
// Assumes: sees top-level ports only
// Notes:   bound onto the top module below
`timescale 1ns/1ps
`default_nettype none
module arltim_asserts
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        pslverr,
  input wire logic        irq_wrap,
  input wire logic        irq_match
);
  wire logic [7:0] ix  = paddr[9:2];
  wire logic       hit = paddr[11:10] == 2'h0 && ix >= 8'he5 &&
                         ix <= 8'heb && ix != 8'he8;
  wire logic       md  = hit && ix == arltim_pkg::mode_control_idx;
  wire logic       mw  = md && psel && penable && pready && pwrite;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // bus and request checks
  // ------------------------------------------------------------
  chk_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  chk_ready_only: assert property (pready |-> psel && penable)
    else $error("ready outside access");
  chk_ready_once: assert property (pready |=> !pready)
    else $error("ready held too long");
  chk_err_map: assert property (pready |-> pslverr == !hit)
    else $error("wrong error response");
  chk_read_upper: assert property (pready && !pwrite |->
    (prdata >> (pslverr ? 0 : 8)) == 32'h0)
    else $error("read data bits set");
  chk_mode_read: assert property (
    pready && !pwrite && md |-> (prdata[7:0] & 8'hb3) == 8'h0)
    else $error("mode reads reserved or load bit");
  chk_wrap_mask: assert property (mw && !pwdata[2] |=> !irq_wrap)
    else $error("wrap request while masked");
  chk_match_mask: assert property (mw && !pwdata[3] |=> !irq_match)
    else $error("match request while masked");
endmodule
bind arltim_top arltim_asserts u_arltim_asserts (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .irq_wrap(irq_wrap), .irq_match(irq_match));
`default_nettype wire

//--- verification/tb_top.sv
// Purpose: self-checking bench for the timer
// Assumes: apb slave, counter model in integers
// Notes:   random values from an xorshift seed
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq_wrap, irq_match, er;
  int          err_total = 0, samples_checked = 0, cyc = 0, acc, e;
  int unsigned seed = 66558;
  always #5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  arltim_top u_arltim_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .irq_wrap(irq_wrap), .irq_match(irq_match));
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic int unsigned xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic end_sim();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] s, x);
    samples_checked++;
    if (s !== x)
    begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input int d);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'h0, ix, 2'h0};
    pwdata <= 32'(d & 'hff);
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1)
    begin
      err_total++;
      end_sim();
    end
    rd = prdata;
    er = pslverr;
    acc = cyc;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  // load, run for a while, stop, read the count
  task automatic timed(input int cs, w, ie, rl);
    int t0;
    apb(1, arltim_pkg::reload_value_idx, rl);
    apb(1, arltim_pkg::clock_select_idx, cs);
    apb(1, arltim_pkg::mode_control_idx, 'hc0 | ie);
    t0 = acc;
    repeat (w) @(posedge pclk);
    apb(1, arltim_pkg::mode_control_idx, ie);
    e = acc - t0;
    apb(0, arltim_pkg::live_counter_idx, 0);
  endtask
  task automatic run_case(input int dv);
    int rl, mt, ie, cnt, wf, mf;
    rl = 'hf0 | xs() % 16;
    mt = rl + xs() % (256 - rl);
    ie = xs() & 'hc;
    apb(1, arltim_pkg::match_value_idx, mt);
    timed(dv << 5, (12 << dv) + xs() % 64, ie, rl);
    cnt = rl;
    wf = 0;
    mf = 0;
    for (int i = 1; i <= e; i++)
    begin
      if (cnt == mt) mf = 1;
      if (i % (1 << dv) == 0) cnt++;
      wf |= (cnt == 256);
      if (cnt == 256) cnt = rl;
    end
    chk("count", rd, cnt);
    apb(0, arltim_pkg::flag_idx, 0);
    chk("flags", rd, mf * 2 + wf);
    chk("irq", {irq_match, irq_wrap}, (mf * 2 + wf) & (ie >> 2));
    apb(1, arltim_pkg::flag_idx, 'hff);
    apb(0, arltim_pkg::flag_idx, 0);
    chk("flag keep", rd, mf * 2 + wf);
    apb(1, arltim_pkg::flag_idx, 0);
    apb(0, arltim_pkg::mode_control_idx, 0);
    chk("mode", rd, ie);
    apb(0, arltim_pkg::flag_idx, 0);
    chk("flag clear", rd, 0);
    apb(0, arltim_pkg::live_counter_idx, 0);
    chk("hold", rd, cnt);
  endtask
  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(0, arltim_pkg::mode_control_idx, 0);
    chk("mode reset", rd, 0);
    apb(0, arltim_pkg::live_counter_idx, 0);
    chk("count reset", rd, 0);
    apb(0, 8'he8, 0);
    chk("unmapped", {rd[30:0], er}, 1);
    apb(1, arltim_pkg::live_counter_idx, 'h5a);
    apb(0, arltim_pkg::live_counter_idx, 0);
    chk("live", rd, 'h5a);
    for (int d = 0; d < 8; d++)
      run_case(d);
    timed(1, 100, 0, 0);
    chk("div3", rd, e / 3);
    timed(2, 50, 0, 0);
    chk("reserved", rd, 0);
    end_sim();
  end
endmodule
`default_nettype wire
